// *** rtl/mssr_debounce.sv ***
// Purpose: Debounce one synchronous level input
// Assumes: tick is a one-cycle enable
// Notes: Output changes after a stable run of tick periods
`timescale 1ns/1ns
`default_nettype none
module mssr_debounce #(
  parameter int unsigned STABLE_TICKS = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sample
  input wire logic tick,
  input wire logic raw,
  output logic clean
);
  logic s1;
  logic s2;
  logic [15:0] cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      clean <= 1'b0;
    end else if (s2 == clean) begin
      cnt <= 16'h0000;
    end else if (tick) begin
      if (cnt >= 16'(STABLE_TICKS - 1)) begin
        clean <= s2;
        cnt <= 16'h0000;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/mssr_defines.svh ***
// Purpose: Constants for the mode switch and reset sequencer
// Assumes: 25 MHz pclk
// Notes: Offsets are APB byte addresses
`ifndef MSSR_DEFINES_SVH
`define MSSR_DEFINES_SVH
`define MSSR_CLK_HZ 25000000
`define MSSR_TICK_MS 1
`define MSSR_TICK_CYC ((`MSSR_CLK_HZ / 1000) * `MSSR_TICK_MS)
`define MSSR_FAST_HALF_MS 250
`define MSSR_SLOW_HALF_MS 1000
`define MSSR_RESET_RUN_MS 3000
`define MSSR_HOLD_STEP_MS 1000
`define MSSR_REARM_MS 3000
`define MSSR_DEBOUNCE_MS 10
`define MSSR_ERASE_WORDS 16
`define MSSR_OFF_CTRL 12'h000
`define MSSR_OFF_STATUS 12'h004
`define MSSR_OFF_UTIL 12'h008
`define MSSR_OFF_NETADDR 12'h00c
`define MSSR_OFF_HOURS 12'h010
`define MSSR_OFF_ID 12'h014
`define MSSR_CTRL_HOT_BIT 0
`define MSSR_CTRL_REQ_BIT 1
`define MSSR_CTRL_RESET 32'h0000_0000
// Arbitrary identification value, chosen freely
`define MSSR_ID_VALUE 32'h00c0_ffee
`endif

// *** rtl/mssr_pkg.sv ***
// Purpose: Types for the mode switch and reset sequencer
// Assumes: Nothing
// Notes: Binary state codes
package mssr_pkg;
  typedef enum logic [1:0] {
    MSSR_SEL_STOP = 2'b00,
    MSSR_SEL_RUN = 2'b01,
    MSSR_SEL_MEMORY_RESET_POSITION = 2'b10
  } mssr_sel_t;
  typedef enum logic [3:0] {
    MSSR_ST_IDLE = 4'h0,
    MSSR_ST_HOLD1 = 4'h1,
    MSSR_ST_HOLD2 = 4'h2,
    MSSR_ST_HOLD3 = 4'h3,
    MSSR_ST_ARMED = 4'h4,
    MSSR_ST_REARM = 4'h5,
    MSSR_ST_CONFIRM = 4'h6,
    MSSR_ST_RESET = 4'h7,
    MSSR_ST_RUN = 4'h8,
    MSSR_ST_REQ_MEMORY_RESET_POSITION = 4'h9
  } mssr_state_t;
endpackage

// *** rtl/mssr_top.sv ***
// Functional notes
// - Power-on lights restart lamp, auto reset with 2 Hz stop flash, then steady.
// - Pending reset request flashes stop lamp at 0.5 Hz until memory reset starts.
// - Stop position, nothing pending, stop lamp steady on.
// - Holding reset position: lamp off, on, off one second each, then on.
// - Back to stop, reset again within 3 s, back to stop launches reset.
// - During memory reset lamp flashes 2 Hz at least 3 s, then steady.
// - With request pending, one reset-and-back move runs the memory reset.
// - Memory reset erases user program in main and load memory.
// - Memory reset clears counters, bit memory, timers; time of day kept.
// - Memory reset runs self-test and loads default parameters.
// - Flash card present: copy stored program and parameters after reset.
// - No flash card at reset end: utilization clears to zero, then tracks core_used.
// - Keep diagnostics, network address, time of day, hours counter.
// - Card network parameters are loaded and validated during reset.
// - Warm restart clears process image and non-retentive data.
// - Warm restart restores non-retaining data blocks to load values.
// - Warm restart begins execution at startup or main cyclic routine.
// - Hot restart keeps data and resumes at interruption point.
// - Hot restart holds outputs until current cycle ends.
// - After supply loss, restarts only offered with memory backup.
// - Stop to run triggers warm or hot restart per configuration.
// - Card change powered raises request; unpowered forces reset at power-on.
// Purpose: Mode selector, memory reset and restart sequencer with APB registers
// Assumes: Selector and card inputs synchronous to pclk; core acknowledges actions
// Notes: Memory actions are strobes to the core; the sequencer owns only timing
`timescale 1ns/1ns
`default_nettype none
`include "mssr_defines.svh"
module mssr_top #(
  parameter int unsigned TICK_CYC = `MSSR_TICK_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operator selector and card
  input wire logic sel_run,
  input wire logic sel_memory_reset_position,
  input wire logic card_present,
  input wire logic card_is_flash,
  input wire logic card_has_net,
  input wire logic card_changed_unpowered,
  input wire logic backup_active,
  // Core handshake
  input wire logic core_done,
  input wire logic cycle_end,
  input wire logic [15:0] core_used,
  // Indicators
  output logic stop_led,
  output logic restart_indicator,
  // Core actions
  output logic erase_program,
  output logic clear_data,
  output logic self_test,
  output logic load_defaults,
  output logic load_net_params,
  output logic copy_flash,
  output logic warm_restart,
  output logic hot_restart,
  output logic hold_outputs,
  output logic restore_data_blocks,
  output logic start_at_entry
);
  // ---------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------
  logic [24:0] div;
  logic tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 25'h0;
      tick <= 1'b0;
    end else begin
      tick <= (div == 25'(TICK_CYC - 1));
      div <= (div == 25'(TICK_CYC - 1)) ? 25'h0 : div + 25'h1;
    end
  end

  // ---------------------------------------------------------------
  // Selector conditioning
  // ---------------------------------------------------------------
  logic run_c;
  logic memory_reset_position_c;
  mssr_debounce #(.STABLE_TICKS(`MSSR_DEBOUNCE_MS)) u_db_run (
    .pclk(pclk), .presetn(presetn), .tick(tick), .raw(sel_run), .clean(run_c));
  mssr_debounce #(.STABLE_TICKS(`MSSR_DEBOUNCE_MS)) u_db_memory_reset_position (
    .pclk(pclk), .presetn(presetn), .tick(tick), .raw(sel_memory_reset_position), .clean(memory_reset_position_c));
  mssr_pkg::mssr_sel_t pos;
  assign pos = memory_reset_position_c ? mssr_pkg::MSSR_SEL_MEMORY_RESET_POSITION :
               (run_c ? mssr_pkg::MSSR_SEL_RUN : mssr_pkg::MSSR_SEL_STOP);

  // ---------------------------------------------------------------
  // Card change detection
  // ---------------------------------------------------------------
  logic card_q;
  logic card_edge;
  logic strap_taken;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_q <= 1'b0;
      strap_taken <= 1'b0;
    end else begin
      card_q <= card_present;
      strap_taken <= 1'b1;
    end
  end
  assign card_edge = strap_taken && (card_q != card_present);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic sw_req;
  logic apb_wr;
  logic [15:0] util;
  logic [31:0] hours;
  logic [7:0] netaddr;
  assign apb_wr = psel && penable && pwrite;
  assign sw_req = apb_wr && paddr == `MSSR_OFF_CTRL && pwdata[`MSSR_CTRL_REQ_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `MSSR_CTRL_RESET;
    end else if (apb_wr && paddr == `MSSR_OFF_CTRL) begin
      ctrl <= {31'h0, pwdata[`MSSR_CTRL_HOT_BIT]};
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  mssr_pkg::mssr_state_t state;
  logic [12:0] ms;
  logic req_pending;
  logic power_on;
  logic had_loss;
  logic reset_done;
  localparam logic [12:0] STEP = 13'(`MSSR_HOLD_STEP_MS);
  localparam logic [12:0] RUNT = 13'(`MSSR_RESET_RUN_MS);
  localparam logic [12:0] REARM = 13'(`MSSR_REARM_MS);

  // Request sets win over the clear made by a finishing reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_pending <= 1'b0;
    end else if (card_edge || sw_req) begin
      req_pending <= 1'b1;
    end else if (reset_done) begin
      req_pending <= 1'b0;
    end
  end

  assign reset_done = (state == mssr_pkg::MSSR_ST_RESET) && tick && ms >= RUNT && core_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mssr_pkg::MSSR_ST_RESET;
      ms <= 13'h0;
      power_on <= 1'b1;
      had_loss <= 1'b1;
    end else begin
      if (tick && ms != 13'h1fff) begin
        ms <= ms + 13'h1;
      end
      unique case (state)
        mssr_pkg::MSSR_ST_IDLE: begin
          if (pos == mssr_pkg::MSSR_SEL_MEMORY_RESET_POSITION) begin
            state <= req_pending ? mssr_pkg::MSSR_ST_CONFIRM : mssr_pkg::MSSR_ST_HOLD1;
            ms <= 13'h0;
          end else if (pos == mssr_pkg::MSSR_SEL_RUN && !req_pending &&
                       (!had_loss || backup_active)) begin
            state <= mssr_pkg::MSSR_ST_RUN;
            had_loss <= 1'b0;
          end
        end
        mssr_pkg::MSSR_ST_HOLD1, mssr_pkg::MSSR_ST_HOLD2, mssr_pkg::MSSR_ST_HOLD3: begin
          if (pos != mssr_pkg::MSSR_SEL_MEMORY_RESET_POSITION) begin
            state <= mssr_pkg::MSSR_ST_IDLE;
          end else if (tick && ms >= STEP - 13'h1) begin
            ms <= 13'h0;
            state <= (state == mssr_pkg::MSSR_ST_HOLD1) ? mssr_pkg::MSSR_ST_HOLD2 :
                     (state == mssr_pkg::MSSR_ST_HOLD2) ? mssr_pkg::MSSR_ST_HOLD3 :
                     mssr_pkg::MSSR_ST_ARMED;
          end
        end
        mssr_pkg::MSSR_ST_ARMED: begin
          if (pos == mssr_pkg::MSSR_SEL_STOP) begin
            state <= mssr_pkg::MSSR_ST_REARM;
            ms <= 13'h0;
          end else if (pos == mssr_pkg::MSSR_SEL_RUN) begin
            state <= mssr_pkg::MSSR_ST_IDLE;
          end
        end
        mssr_pkg::MSSR_ST_REARM: begin
          if (pos == mssr_pkg::MSSR_SEL_MEMORY_RESET_POSITION) begin
            state <= mssr_pkg::MSSR_ST_CONFIRM;
          end else if (pos == mssr_pkg::MSSR_SEL_RUN || (tick && ms >= REARM)) begin
            state <= mssr_pkg::MSSR_ST_IDLE;
          end
        end
        mssr_pkg::MSSR_ST_CONFIRM: begin
          if (pos == mssr_pkg::MSSR_SEL_STOP) begin
            state <= mssr_pkg::MSSR_ST_RESET;
            ms <= 13'h0;
          end else if (pos == mssr_pkg::MSSR_SEL_RUN) begin
            state <= mssr_pkg::MSSR_ST_IDLE;
          end
        end
        mssr_pkg::MSSR_ST_RESET: begin
          if (reset_done) begin
            state <= mssr_pkg::MSSR_ST_IDLE;
            power_on <= 1'b0;
          end
        end
        mssr_pkg::MSSR_ST_RUN: begin
          if (pos != mssr_pkg::MSSR_SEL_RUN) begin
            state <= mssr_pkg::MSSR_ST_IDLE;
          end
        end
        default: begin
          state <= mssr_pkg::MSSR_ST_IDLE;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------
  // Core action strobes
  // ---------------------------------------------------------------
  logic entering_reset;
  logic entering_run;
  logic in_reset_q;
  logic in_run_q;
  logic hot_pending;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reset_q <= 1'b0;
      in_run_q <= 1'b0;
    end else begin
      in_reset_q <= state == mssr_pkg::MSSR_ST_RESET;
      in_run_q <= state == mssr_pkg::MSSR_ST_RUN;
    end
  end
  assign entering_reset = state == mssr_pkg::MSSR_ST_RESET && !in_reset_q;
  assign entering_run = state == mssr_pkg::MSSR_ST_RUN && !in_run_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {erase_program, clear_data, self_test, load_defaults, load_net_params} <= 5'h00;
      {copy_flash, warm_restart, hot_restart, restore_data_blocks, start_at_entry} <= 5'h00;
    end else begin
      erase_program <= entering_reset;
      clear_data <= entering_reset;
      self_test <= entering_reset;
      load_defaults <= entering_reset;
      load_net_params <= entering_reset && card_present && card_has_net;
      copy_flash <= reset_done && card_present && card_is_flash;
      warm_restart <= entering_run && !ctrl[`MSSR_CTRL_HOT_BIT];
      restore_data_blocks <= entering_run && !ctrl[`MSSR_CTRL_HOT_BIT];
      start_at_entry <= entering_run && !ctrl[`MSSR_CTRL_HOT_BIT];
      hot_restart <= entering_run && ctrl[`MSSR_CTRL_HOT_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_pending <= 1'b0;
    end else if (entering_run && ctrl[`MSSR_CTRL_HOT_BIT]) begin
      hot_pending <= 1'b1;
    end else if (cycle_end) begin
      hot_pending <= 1'b0;
    end
  end
  assign hold_outputs = hot_pending;

  // ---------------------------------------------------------------
  // Indicators and preserved state
  // ---------------------------------------------------------------
  logic fast_ph;
  logic slow_ph;
  logic [9:0] fast_cnt;
  logic [9:0] slow_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_cnt <= 10'h0;
      slow_cnt <= 10'h0;
      fast_ph <= 1'b1;
      slow_ph <= 1'b1;
    end else if (tick) begin
      fast_cnt <= (fast_cnt == 10'(`MSSR_FAST_HALF_MS - 1)) ? 10'h0 : fast_cnt + 10'h1;
      slow_cnt <= (slow_cnt == 10'(`MSSR_SLOW_HALF_MS - 1)) ? 10'h0 : slow_cnt + 10'h1;
      if (fast_cnt == 10'(`MSSR_FAST_HALF_MS - 1)) begin
        fast_ph <= !fast_ph;
      end
      if (slow_cnt == 10'(`MSSR_SLOW_HALF_MS - 1)) begin
        slow_ph <= !slow_ph;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_led <= 1'b0;
      restart_indicator <= 1'b0;
    end else begin
      restart_indicator <= power_on;
      if (state == mssr_pkg::MSSR_ST_RESET) begin
        stop_led <= fast_ph;
      end else if (state == mssr_pkg::MSSR_ST_HOLD1 || state == mssr_pkg::MSSR_ST_HOLD3) begin
        stop_led <= 1'b0;
      end else if (req_pending) begin
        stop_led <= slow_ph;
      end else begin
        stop_led <= state != mssr_pkg::MSSR_ST_RUN;
      end
    end
  end

  // Card swapped while off forces the power-on reset; reset state already covers it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      util <= 16'h0;
      hours <= 32'h0;
      netaddr <= 8'h0;
    end else begin
      if (reset_done && !(card_present && card_is_flash)) begin
        util <= 16'h0;
      end else if (state != mssr_pkg::MSSR_ST_RESET) begin
        util <= core_used;
      end
      if (apb_wr && paddr == `MSSR_OFF_NETADDR) begin
        netaddr <= pwdata[7:0];
      end
      if (apb_wr && paddr == `MSSR_OFF_HOURS) begin
        hours <= pwdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // APB read side
  // ---------------------------------------------------------------
  logic known;
  assign pready = 1'b1;
  assign known = paddr == `MSSR_OFF_CTRL || paddr == `MSSR_OFF_STATUS ||
                 paddr == `MSSR_OFF_UTIL || paddr == `MSSR_OFF_NETADDR ||
                 paddr == `MSSR_OFF_HOURS || paddr == `MSSR_OFF_ID;
  assign pslverr = psel && penable && !known;
  always_comb begin
    unique case (paddr)
      `MSSR_OFF_CTRL: prdata = ctrl;
      `MSSR_OFF_STATUS: prdata = {23'h0, card_changed_unpowered, card_present, req_pending,
                                  state, pos};
      `MSSR_OFF_UTIL: prdata = {16'h0, util};
      `MSSR_OFF_NETADDR: prdata = {24'h0, netaddr};
      `MSSR_OFF_HOURS: prdata = hours;
      `MSSR_OFF_ID: prdata = `MSSR_ID_VALUE;
      default: prdata = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence launch_s;
    state == mssr_pkg::MSSR_ST_CONFIRM && pos == mssr_pkg::MSSR_SEL_STOP;
  endsequence
  sequence reset_begun_s;
    state == mssr_pkg::MSSR_ST_RESET ##1 (erase_program && clear_data);
  endsequence
  restart_clears_a: assert property (state == mssr_pkg::MSSR_ST_IDLE |->
    ##1 !restart_indicator)
    else $error("restart indicator stuck");
  req_flash_a: assert property (req_pending && state == mssr_pkg::MSSR_ST_IDLE |=>
    stop_led == $past(slow_ph))
    else $error("request flash wrong");
  stop_steady_a: assert property (state == mssr_pkg::MSSR_ST_IDLE && !req_pending |=>
    stop_led)
    else $error("stop lamp not steady");
  hold_off_a: assert property (state == mssr_pkg::MSSR_ST_HOLD1 |=> !stop_led)
    else $error("hold pattern wrong");
  confirm_launch_a: assert property (launch_s |=> reset_begun_s)
    else $error("reset not launched");
  // Judged on leaving the state, so any exit path is covered
  reset_min_a: assert property ($fell(state == mssr_pkg::MSSR_ST_RESET) |->
    $past(ms) >= RUNT)
    else $error("reset too short");
  erase_pulse_a: assert property (entering_reset |=> erase_program && clear_data)
    else $error("erase not issued");
  hot_choice_a: assert property (entering_run |=>
    hot_restart == $past(ctrl[`MSSR_CTRL_HOT_BIT]) && warm_restart != hot_restart)
    else $error("restart kind wrong");
endmodule
`default_nettype wire

// *** test/mode_switch_reset_sequencer_bench.sv ***
// Purpose: Self-checking bench for the mode selector and reset sequencer
// Assumes: One tick is TK cycles, so one millisecond of lamp time is TK cycles
// Notes: Lamp rates are judged by toggle counts with one toggle of slack
`timescale 1ns/1ns
`default_nettype none
`include "mssr_defines.svh"
module mode_switch_reset_sequencer_bench;
  localparam int TK = 2;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sel_run, sel_memory_reset_position, card_present, last_led;
  logic card_in = 0;
  logic card_is_flash = 0;
  logic card_has_net = 0;
  logic backup_active = 0;
  logic card_chg_off = 0;
  logic [31:0] hrs;
  logic core_done = 1;
  logic cycle_end = 0;
  logic [15:0] core_used = 16'h0;
  logic [1:0] pos = 2'h0;
  logic stop_led, restart_indicator, hold_outputs;
  wire [9:0] acts;
  int got[10];
  int exp_cnt[10];
  int mismatches = 0;
  int n_compared = 0;
  int n_toggle = 0;
  int cycles = 0;

  mssr_top #(.TICK_CYC(TK)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sel_run(sel_run), .sel_memory_reset_position(sel_memory_reset_position),
    .card_present(card_present), .card_is_flash(card_is_flash), .card_has_net(card_has_net),
    .card_changed_unpowered(card_chg_off), .backup_active(backup_active), .core_done(core_done),
    .cycle_end(cycle_end), .core_used(core_used), .stop_led(stop_led),
    .restart_indicator(restart_indicator), .erase_program(acts[0]), .clear_data(acts[1]),
    .self_test(acts[2]), .load_defaults(acts[3]), .load_net_params(acts[4]),
    .copy_flash(acts[5]), .warm_restart(acts[6]), .hot_restart(acts[7]),
    .hold_outputs(hold_outputs), .restore_data_blocks(acts[8]), .start_at_entry(acts[9]));
  mssr_panel_model u_panel (.pclk(pclk), .pos(pos), .card_in(card_in), .sel_run(sel_run),
    .sel_memory_reset_position(sel_memory_reset_position), .card_present(card_present));

  // ----------------------------------------
  // Clock, monitors, timeout
  // ----------------------------------------
  initial begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    for (int i = 0; i < 10; i++) begin
      if (acts[i] === 1'b1) got[i]++;
    end
    if (stop_led !== last_led) n_toggle++;
    last_led = stop_led;
    if (cycles == 70000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic ms(int n);
    repeat (n * TK) @(posedge pclk);
  endtask
  // Request held until pready is sampled high at an edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic move(logic [1:0] p, int hold);
    @(posedge pclk);
    pos <= p;
    ms(hold);
  endtask
  task automatic flash(int win, int lo, int hi);
    int t0;
    t0 = n_toggle;
    ms(win);
    check("lamp toggles", 32'(n_toggle - t0 >= lo && n_toggle - t0 <= hi), 32'h1);
  endtask
  task automatic acts_ok();
    for (int i = 0; i < 10; i++) check("action pulses", got[i], exp_cnt[i]);
  endtask
  task automatic reset_seen();
    ms(100);
    flash(2800, 10, 12);
    ms(700);
    flash(300, 0, 0);
    check("lamp steady", stop_led, 32'h1);
    for (int i = 0; i < 4; i++) exp_cnt[i]++;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(23089));
    core_used <= 16'($urandom);
    card_chg_off <= 1'($urandom);
    hrs = $urandom;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    ms(100);
    flash(2800, 10, 12);
    check("restart lamp", restart_indicator, 32'h1);
    ms(700);
    flash(300, 0, 0);
    check("lamp steady", stop_led, 32'h1);
    foreach (got[i]) got[i] = 0;
    move(2'h1, 100);
    check("run refused lamp", stop_led, 32'h1);
    acts_ok();
    move(2'h0, 100);
    backup_active <= 1'b1;
    $display("test power_on done");
    apb(1'b0, `MSSR_OFF_ID, 32'h0);
    check("id", rd, `MSSR_ID_VALUE);
    apb(1'b0, `MSSR_OFF_CTRL, 32'h0);
    check("ctrl reset", rd, `MSSR_CTRL_RESET);
    apb(1'b0, `MSSR_OFF_UTIL, 32'h0);
    check("util", {16'h0, rd[15:0]}, {16'h0, core_used});
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped error", 32'({rd, err} == 33'h1), 32'h1);
    apb(1'b0, `MSSR_OFF_STATUS, 32'h0);
    check("status card bits", {29'h0, rd[8:6]}, {29'h0, card_chg_off, 2'b00});
    apb(1'b1, `MSSR_OFF_HOURS, hrs);
    apb(1'b1, `MSSR_OFF_NETADDR, 32'h5a);
    $display("test registers done");
    move(2'h2, 500);
    for (int i = 0; i < 4; i++) begin
      check("hold lamp", stop_led, 32'(i % 2));
      ms(1000);
    end
    move(2'h0, 300);
    move(2'h2, 300);
    move(2'h0, 0);
    reset_seen();
    acts_ok();
    apb(1'b0, `MSSR_OFF_HOURS, 32'h0);
    check("hours kept", rd, hrs);
    apb(1'b0, `MSSR_OFF_NETADDR, 32'h0);
    check("net address kept", rd, 32'h5a);
    $display("test selector_reset done");
    apb(1'b1, `MSSR_OFF_CTRL, 32'h2);
    ms(50);
    flash(4000, 3, 5);
    move(2'h1, 200);
    move(2'h0, 200);
    acts_ok();
    move(2'h2, 200);
    move(2'h0, 0);
    reset_seen();
    acts_ok();
    $display("test request_reset done");
    @(posedge pclk);
    card_is_flash <= 1'b1;
    card_has_net <= 1'b1;
    card_in <= 1'b1;
    ms(50);
    flash(3000, 2, 4);
    move(2'h2, 200);
    move(2'h0, 0);
    exp_cnt[4]++;
    exp_cnt[5]++;
    reset_seen();
    acts_ok();
    $display("test card_reset done");
    move(2'h1, 100);
    exp_cnt[6]++;
    exp_cnt[8]++;
    exp_cnt[9]++;
    acts_ok();
    move(2'h0, 100);
    apb(1'b1, `MSSR_OFF_CTRL, 32'h1);
    apb(1'b0, `MSSR_OFF_CTRL, 32'h0);
    check("hot select", rd[0], 32'h1);
    move(2'h1, 100);
    exp_cnt[7]++;
    acts_ok();
    check("outputs held", hold_outputs, 32'h1);
    @(posedge pclk);
    cycle_end <= 1'b1;
    @(posedge pclk);
    cycle_end <= 1'b0;
    repeat (3) @(posedge pclk);
    check("outputs freed", hold_outputs, 32'h0);
    $display("test restarts done");
    end_of_test();
  end
endmodule
`default_nettype wire

// *** test/mssr_panel_model.sv ***
// Purpose: Operator selector and memory card model
// Assumes: Bench sets the wanted position and card state
// Notes: Contacts chatter for eight cycles after every move
`timescale 1ns/1ns
`default_nettype none
module mssr_panel_model (
  // Clock
  input wire logic pclk,
  // Commands from the bench
  input wire logic [1:0] pos,
  input wire logic card_in,
  // Pins toward the device
  output logic sel_run,
  output logic sel_memory_reset_position,
  output logic card_present
);
  logic [1:0] last_pos = 2'h0;
  int chatter = 0;
  // Real contacts bounce; a clean model would hide a weak debouncer
  always @(posedge pclk) begin
    if (pos != last_pos) begin
      chatter <= 8;
    end else if (chatter > 0) begin
      chatter <= chatter - 1;
    end
    last_pos <= pos;
    sel_run <= (chatter > 0) ? 1'($urandom) : (pos == 2'h1);
    sel_memory_reset_position <= (chatter > 0) ? 1'($urandom) : (pos == 2'h2);
    card_present <= card_in;
  end
endmodule
`default_nettype wire
